// file: tb/ivpm_periph_model.sv
// Peripheral side model: raises one numbered source event line for one cycle.
`timescale 1ns/10ps
`default_nettype none
module ivpm_periph_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [5:0] num,
  output logic [36:0]     src_event
);
  initial src_event = 37'h0;
  // Each peripheral owns one fixed line, present or not, so numbering never shifts.
  always @(posedge clk) begin
    src_event <= fire ? (37'h1 << num) : 37'h0;
  end
endmodule
`default_nettype wire

// file: tb/ivpm_top_tb.sv
// Self-checking bench of the interrupt vector priority map.
`timescale 1ns/10ps
`default_nettype none
module ivpm_top_tb;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic [7:0]           addr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic                 nmi = 1'b0;
  logic                 dbg = 1'b0;
  logic                 fetch = 1'b0;
  logic                 fire = 1'b0;
  logic [5:0]           num = 6'h00;
  logic [36:0]          src_event;
  logic [31:0]          rdata;
  ivpm_pkg::ivpm_core_t core;
  logic                 int_out;
  ivpm_pkg::ivpm_exc_t  exc;
  int                   fail_count = 0;
  int                   compares = 0;
  // Rows: request, vector, priority word, base bit of its field.
  int rows [14][4] = '{'{0,0,0,0}, '{1,1,0,8}, '{2,2,0,16}, '{22,22,5,16},
    '{23,23,5,24}, '{25,23,5,24}, '{26,24,6,0}, '{28,24,6,0}, '{29,25,6,8},
    '{31,25,6,8}, '{32,26,6,16}, '{33,27,6,24}, '{35,29,7,8}, '{36,30,7,16}};

  always #2.5 clk = ~clk;

  ivpm_periph_model MODEL (.clk(clk), .fire(fire), .num(num), .src_event(src_event));

  ivpm_top DUT (.CLK(clk), .RESET(reset), .SRC_EVENT(src_event), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .NMI_REQ(nmi),
    .DEBUG_REQ(dbg), .FETCH_FAULT(fetch), .CORE_IRQ(core), .INT_OUT(int_out),
    .EXC_SEL(exc));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(37'(rdata), 37'(exp));
  endtask

  task automatic fire_src(input int n);
    @(posedge clk);
    fire <= 1'b1;
    num <= 6'(n);
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int n;
    logic [7:0] fa;
    logic [7:0] pa;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    chk({core, int_out, exc}, {11'h0, 1'b0, ivpm_pkg::EXC_NONE});
    $display("Reset test done");
    foreach (rows[i]) begin
      n = rows[i][0];
      fa = (n >= 32) ? 8'h04 : 8'h00;
      pa = 8'h20 + 8'(4 * rows[i][2]);
      wr_reg(fa + 8'h10, 32'h1 << (n % 32));
      wr_reg(pa, 32'h1F << rows[i][3]);
      fire_src(n);
      tick(4);
      rd_chk(fa, 32'h1 << (n % 32));
      chk(37'(core.vector), 37'(rows[i][1]));
      chk({core.req, core.prio, core.sub, int_out}, 7'h7F);
      chk(exc, ivpm_pkg::EXC_INT);
      wr_reg(fa, 32'h1 << (n % 32));
      wr_reg(fa + 8'h10, 32'h0);
      wr_reg(pa, 32'h0);
      tick(3);
      chk(int_out, 1'b0);
      $display("Map test for request %0d done", n);
    end
    // A masked source still flags and requests once unmasked.
    fire_src(5);
    tick(4);
    chk(int_out, 1'b0);
    rd_chk(8'h00, 32'h20);
    wr_reg(8'h10, 32'h28);
    tick(3);
    chk(int_out, 1'b1);
    $display("Mask test done");
    wr_reg(8'h24, 32'h0000_0800);
    wr_reg(8'h20, 32'h1400_0000);
    wr_reg(8'h08, 32'h8);
    tick(3);
    chk(37'(core.vector), 37'h3);
    wr_reg(8'h20, 32'h0800_0000);
    tick(3);
    chk(37'(core.vector), 37'h3);
    wr_reg(8'h24, 32'h0000_0900);
    tick(3);
    chk(37'(core.vector), 37'h5);
    rd_chk(8'h18, 32'h0000_04A9);
    $display("Arbitration test done");
    fetch <= 1'b1;
    tick(2);
    chk(exc, ivpm_pkg::EXC_INT);
    nmi <= 1'b1;
    tick(2);
    chk(exc, ivpm_pkg::EXC_NMI);
    dbg <= 1'b1;
    tick(2);
    chk(exc, ivpm_pkg::EXC_DEBUG);
    dbg <= 1'b0;
    nmi <= 1'b0;
    wr_reg(8'h00, 32'h28);
    tick(3);
    chk(exc, ivpm_pkg::EXC_FETCH);
    fetch <= 1'b0;
    $display("Ranking test done");
    wr_reg(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h001F_1F1F);
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    $display("Register space test done");
    conclude();
  end
endmodule
`default_nettype wire

// file: verilog/ivpm_pkg.sv
// Shared constants, types and helpers of the interrupt vector priority map.
`default_nettype none
package ivpm_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_SRC    = 37;
  localparam int NUM_VEC    = 31;
  localparam int VEC_W      = 5;
  localparam int PRIO_WORDS = 8;
  localparam int ADDR_W     = 8;
  localparam int LOW_SRCS   = 32;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_FLAGS_LOW   = 8'h00;
  localparam logic [7:0] OFS_FLAGS_HIGH  = 8'h04;
  localparam logic [7:0] OFS_SET_LOW     = 8'h08;
  localparam logic [7:0] OFS_SET_HIGH    = 8'h0C;
  localparam logic [7:0] OFS_ENABLE_LOW  = 8'h10;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'h14;
  localparam logic [7:0] OFS_WINNER      = 8'h18;
  localparam logic [7:0] OFS_PRIO_BASE   = 8'h20;
  localparam logic [7:0] OFS_PRIO_LAST   = 8'h3C;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int PRIO_LSB     = 2;
  localparam int SUB_LSB      = 0;
  localparam int SLOT_STRIDE  = 8;
  localparam int SLOTS        = 4;
  localparam logic [31:0] PRIO_MASK      = 32'h1F1F1F1F;
  localparam logic [31:0] PRIO_MASK_LAST = 32'h001F1F1F;
  localparam logic [NUM_SRC-1:0] ALL_SRC = 37'h1F_FFFF_FFFF;
  localparam logic [2:0] CORE_SRC_MASK   = 3'h7;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

  // Exception kinds offered to the core, one-hot.
  typedef enum logic [4:0] {
    EXC_NONE  = 5'h01,
    EXC_DEBUG = 5'h02,
    EXC_NMI   = 5'h04,
    EXC_INT   = 5'h08,
    EXC_FETCH = 5'h10
  } ivpm_exc_t;

  typedef struct packed {
    logic             req;
    logic [VEC_W-1:0] vector;
    logic [2:0]       prio;
    logic [1:0]       sub;
  } ivpm_core_t;

  typedef struct packed {
    logic [NUM_SRC-1:0]            flags;
    logic [NUM_SRC-1:0]            en;
    logic [PRIO_WORDS-1:0][31:0]   prio;
    logic [31:0]                   rdata;
    ivpm_core_t                    core;
    ivpm_exc_t                     exc;
  } ivpm_state_t;

  // Request number to vector number; shared peripheral groups collapse.
  function automatic logic [VEC_W-1:0] vec_of(input int req);
    int v;
    if (req <= 22) begin
      v = req;
    end else if (req <= 25) begin
      v = 23;
    end else if (req <= 28) begin
      v = 24;
    end else if (req <= 31) begin
      v = 25;
    end else begin
      v = req - 6;
    end
    return v[VEC_W-1:0];
  endfunction

endpackage
`default_nettype wire

// file: verilog/ivpm_top.sv
// Interrupt vector priority map: flags, enables, priorities and core request.
`timescale 1ns/10ps
`default_nettype none

module ivpm_top #(
  parameter logic [36:0] SRC_PRESENT = 37'h1F_FFFF_FFFF
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic [36:0]          SRC_EVENT,
  input  wire logic [7:0]           ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic [31:0]               RDATA,
  input  wire logic                 NMI_REQ,
  input  wire logic                 DEBUG_REQ,
  input  wire logic                 FETCH_FAULT,
  output ivpm_pkg::ivpm_core_t      CORE_IRQ,
  output logic                      INT_OUT,
  output ivpm_pkg::ivpm_exc_t       EXC_SEL
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The core timer and both software sources live in the core itself.
  if ((SRC_PRESENT[2:0] & ivpm_pkg::CORE_SRC_MASK) != ivpm_pkg::CORE_SRC_MASK) begin : g_chk
    $error("Core sources 0 to 2 must be present");
  end

  // ************************************************************
  // State
  // ************************************************************
  ivpm_pkg::ivpm_state_t st_reg;
  ivpm_pkg::ivpm_state_t st_next;

  logic [ivpm_pkg::NUM_SRC-1:0] act;
  logic [ivpm_pkg::NUM_VEC-1:0] vec_act;
  logic [2:0]                   vec_prio [ivpm_pkg::NUM_VEC];
  logic [1:0]                   vec_sub  [ivpm_pkg::NUM_VEC];
  logic                         found;
  logic [4:0]                   best_key;
  logic [ivpm_pkg::VEC_W-1:0]   best_vec;

  // ************************************************************
  // Per-vector priority fields
  // ************************************************************
  // Each vector owns slot v%4 of word v/4; shared groups read one slot.
  for (genvar v = 0; v < ivpm_pkg::NUM_VEC; v++) begin : g_vec
    localparam int W = v / ivpm_pkg::SLOTS;
    localparam int S = (v % ivpm_pkg::SLOTS) * ivpm_pkg::SLOT_STRIDE;
    assign vec_prio[v] = st_reg.prio[W][S+ivpm_pkg::PRIO_LSB +: 3];
    assign vec_sub[v]  = st_reg.prio[W][S+ivpm_pkg::SUB_LSB +: 2];
  end

  // ************************************************************
  // Register write and read decode helpers
  // ************************************************************
  function automatic logic is_wr(input logic [7:0] ofs);
    return WR && (ADDR == ofs);
  endfunction

  function automatic logic is_prio(input logic [7:0] a);
    return (a >= ivpm_pkg::OFS_PRIO_BASE) && (a <= ivpm_pkg::OFS_PRIO_LAST) && (a[1:0] == 2'h0);
  endfunction

  // Word index of a priority address; callers range-check it with is_prio first.
  function automatic logic [2:0] prio_index(input logic [7:0] a);
    return 3'((a - ivpm_pkg::OFS_PRIO_BASE) >> 2);
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [ivpm_pkg::NUM_SRC-1:0] clr;
    logic [ivpm_pkg::NUM_SRC-1:0] set;
    logic [ivpm_pkg::NUM_SRC-1:0] wide;
    logic [2:0]                   widx;
    logic [4:0]                   key;
    clr      = '0;
    set      = '0;
    wide     = '0;
    widx     = 3'h0;
    key      = 5'h00;
    st_next  = st_reg;
    act      = st_reg.flags & st_reg.en;
    vec_act  = '0;
    found    = 1'b0;
    best_key = 5'h00;
    best_vec = '0;

    // Several requests may fold into one vector.
    for (int r = 0; r < ivpm_pkg::NUM_SRC; r++) begin
      if (act[r]) begin
        vec_act[ivpm_pkg::vec_of(r)] = 1'b1;
      end
    end

    // Walking downward with >= lets the lower vector win a full tie.
    for (int v = ivpm_pkg::NUM_VEC - 1; v >= 0; v--) begin
      key = {vec_prio[v], vec_sub[v]};
      if (vec_act[v] && (!found || key >= best_key)) begin
        found    = 1'b1;
        best_key = key;
        best_vec = v[ivpm_pkg::VEC_W-1:0];
      end
    end

    // Flags: write one to clear, set register to raise software requests.
    if (is_wr(ivpm_pkg::OFS_FLAGS_LOW)) begin
      clr[31:0] = WDATA;
    end
    if (is_wr(ivpm_pkg::OFS_FLAGS_HIGH)) begin
      clr[36:32] = WDATA[4:0];
    end
    if (is_wr(ivpm_pkg::OFS_SET_LOW)) begin
      set[31:0] = WDATA;
    end
    if (is_wr(ivpm_pkg::OFS_SET_HIGH)) begin
      set[36:32] = WDATA[4:0];
    end
    // A source event in the clearing cycle survives, and enables are not consulted.
    st_next.flags = ((st_reg.flags & ~clr) | set | SRC_EVENT) & SRC_PRESENT;

    if (is_wr(ivpm_pkg::OFS_ENABLE_LOW)) begin
      st_next.en[31:0] = WDATA & SRC_PRESENT[31:0];
    end
    if (is_wr(ivpm_pkg::OFS_ENABLE_HIGH)) begin
      st_next.en[36:32] = WDATA[4:0] & SRC_PRESENT[36:32];
    end
    if (WR && is_prio(ADDR)) begin
      widx = prio_index(ADDR);
      // Bits between fields and the unused top slot stay zero.
      if (widx == 3'(ivpm_pkg::PRIO_WORDS - 1)) begin
        st_next.prio[widx] = WDATA & ivpm_pkg::PRIO_MASK_LAST;
      end else begin
        st_next.prio[widx] = WDATA & ivpm_pkg::PRIO_MASK;
      end
    end

    // Read data stands only in the cycle after the strobe.
    st_next.rdata = ivpm_pkg::RESET_WORD;
    if (RD) begin
      wide = st_reg.flags;
      if (ADDR == ivpm_pkg::OFS_FLAGS_LOW) begin
        st_next.rdata = wide[31:0];
      end else if (ADDR == ivpm_pkg::OFS_FLAGS_HIGH) begin
        st_next.rdata = {27'h0000000, wide[36:32]};
      end else if (ADDR == ivpm_pkg::OFS_ENABLE_LOW) begin
        st_next.rdata = st_reg.en[31:0];
      end else if (ADDR == ivpm_pkg::OFS_ENABLE_HIGH) begin
        st_next.rdata = {27'h0000000, st_reg.en[36:32]};
      end else if (ADDR == ivpm_pkg::OFS_WINNER) begin
        st_next.rdata = {21'h000000, st_reg.core};
      end else if (is_prio(ADDR)) begin
        st_next.rdata = st_reg.prio[prio_index(ADDR)];
      end
    end

    st_next.core.req    = found;
    st_next.core.vector = best_vec;
    st_next.core.prio   = best_key[4:2];
    st_next.core.sub    = best_key[1:0];

    // Reset itself outranks everything by holding EXC_NONE.
    if (DEBUG_REQ) begin
      st_next.exc = ivpm_pkg::EXC_DEBUG;
    end else if (NMI_REQ) begin
      st_next.exc = ivpm_pkg::EXC_NMI;
    end else if (found) begin
      st_next.exc = ivpm_pkg::EXC_INT;
    end else if (FETCH_FAULT) begin
      st_next.exc = ivpm_pkg::EXC_FETCH;
    end else begin
      st_next.exc = ivpm_pkg::EXC_NONE;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_reg     <= '0;
      st_reg.exc <= ivpm_pkg::EXC_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA    = st_reg.rdata;
  assign CORE_IRQ = st_reg.core;
  assign INT_OUT  = st_reg.core.req;
  assign EXC_SEL  = st_reg.exc;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_flag_sticky: assert property (
    (st_reg.flags[0] && !(WR && ADDR == ivpm_pkg::OFS_FLAGS_LOW && WDATA[0]))
      |=> st_reg.flags[0])
    else $error("Flag dropped without a clear");

  a_event_sets: assert property (
    (|(SRC_EVENT & SRC_PRESENT)) |=>
      ((st_reg.flags & $past(SRC_EVENT & SRC_PRESENT)) == $past(SRC_EVENT & SRC_PRESENT)))
    else $error("Event did not set its flag");

  a_irq_masked: assert property (
    ##1 (INT_OUT == $past(|(st_reg.flags & st_reg.en))))
    else $error("Core request not equal to flagged and enabled");

  a_debug_top: assert property (
    DEBUG_REQ |=> (EXC_SEL == ivpm_pkg::EXC_DEBUG))
    else $error("Debug not ranked first");

  a_nmi_first: assert property (
    (NMI_REQ && !DEBUG_REQ) |=> (EXC_SEL == ivpm_pkg::EXC_NMI))
    else $error("Non-maskable not above interrupt");

  a_absent_zero: assert property (
    (st_reg.flags & ~SRC_PRESENT) == '0)
    else $error("Absent source flagged");

  a_read_low: assert property (
    (RD && ADDR == ivpm_pkg::OFS_FLAGS_LOW) |=> (RDATA == $past(st_reg.flags[31:0]))
    ##1 (RDATA == 32'h0000_0000 || $past(RD)))
    else $error("Low flag read wrong or stuck");

  a_spi_shared: assert property (
    ((act != '0) && ((act & ~(37'h7 << 23)) == '0))
      |=> (CORE_IRQ.vector == 5'h17 && CORE_IRQ.req))
    else $error("Shared serial vector wrong");

  a_timer_zero: assert property (
    (act == 37'h1) |=> (CORE_IRQ.vector == 5'h00 && CORE_IRQ.prio == $past(st_reg.prio[0][4:2])))
    else $error("Core timer vector or priority wrong");

  a_change_vec: assert property (
    (act == (37'h1 << 32)) |=> (CORE_IRQ.vector == 5'h1A))
    else $error("Input change vector wrong");

  // Any lone request 0 to 22 must come out on the vector of the same number.
  a_direct_map: assert property (
    ($onehot(act[22:0]) && act[36:23] == '0)
      |=> ((37'h1 << CORE_IRQ.vector) == $past(act)))
    else $error("Direct request to vector map wrong");

  a_high_map: assert property (
    ($onehot(act[36:32]) && act[31:0] == '0)
      |=> ((37'h1 << (CORE_IRQ.vector + 6)) == $past(act)))
    else $error("High request to vector map wrong");

  a_uart_shared: assert property (
    ((act != '0) && ((act & ~(37'h7 << 26)) == '0))
      |=> (CORE_IRQ.vector == 5'h18 && CORE_IRQ.prio == $past(st_reg.prio[6][4:2])))
    else $error("Shared async serial vector wrong");

  a_twowire_shared: assert property (
    ((act != '0) && ((act & ~(37'h7 << 29)) == '0))
      |=> (CORE_IRQ.vector == 5'h19 && CORE_IRQ.prio == $past(st_reg.prio[6][12:10])))
    else $error("Shared two-wire vector wrong");

  // A full tie between vectors 3 and 5 must go to the lower number.
  a_natural_tie: assert property (
    (act == 37'h28 && {vec_prio[3], vec_sub[3]} == {vec_prio[5], vec_sub[5]})
      |=> (CORE_IRQ.vector == 5'h03))
    else $error("Full tie not won by lower vector");

  a_sub_win: assert property (
    (act == 37'h28 && {vec_prio[5], vec_sub[5]} > {vec_prio[3], vec_sub[3]})
      |=> (CORE_IRQ.vector == 5'h05))
    else $error("Higher priority key did not win");

  a_exc_onehot: assert property (
    $onehot(EXC_SEL))
    else $error("Exception kind not one-hot");

  a_int_over_fetch: assert property (
    (found && !DEBUG_REQ && !NMI_REQ) |=> (EXC_SEL == ivpm_pkg::EXC_INT))
    else $error("Interrupt not above fetch fault");

  a_fetch_last: assert property (
    (FETCH_FAULT && !found && !DEBUG_REQ && !NMI_REQ) |=> (EXC_SEL == ivpm_pkg::EXC_FETCH))
    else $error("Fetch fault not presented");

  // Read data must fall back to zero so a stale word is never taken twice.
  a_rdata_idle: assert property (
    !RD |=> (RDATA == 32'h0000_0000))
    else $error("Read data stood without a read");

  a_high_word: assert property (
    (RD && ADDR == ivpm_pkg::OFS_FLAGS_HIGH)
      |=> (RDATA == {27'h0000000, $past(st_reg.flags[36:32])}))
    else $error("High flag read wrong");

  a_enable_write: assert property (
    (WR && ADDR == ivpm_pkg::OFS_ENABLE_LOW)
      |=> (st_reg.en[31:0] == $past(WDATA & SRC_PRESENT[31:0])))
    else $error("Low enable write lost");

  a_high_enable: assert property (
    (WR && ADDR == ivpm_pkg::OFS_ENABLE_HIGH)
      |=> (st_reg.en[36:32] == $past(WDATA[4:0] & SRC_PRESENT[36:32])))
    else $error("High enable write lost");

  a_absent_enable: assert property (
    (st_reg.en & ~SRC_PRESENT) == '0)
    else $error("Absent source enabled");

  a_clear_flag: assert property (
    (WR && ADDR == ivpm_pkg::OFS_FLAGS_LOW && WDATA[0] && !SRC_EVENT[0])
      |=> !st_reg.flags[0])
    else $error("Flag clear ignored");

  a_set_flag: assert property (
    (WR && ADDR == ivpm_pkg::OFS_SET_LOW)
      |=> ((st_reg.flags[31:0] & $past(WDATA)) == $past(WDATA)))
    else $error("Software set did not raise flag");

  a_prio_write: assert property (
    (WR && ADDR == ivpm_pkg::OFS_PRIO_BASE)
      |=> (st_reg.prio[0] == $past(WDATA & ivpm_pkg::PRIO_MASK)))
    else $error("Priority word write wrong");

  a_winner_read: assert property (
    (RD && ADDR == ivpm_pkg::OFS_WINNER)
      |=> (RDATA == {21'h000000, $past(st_reg.core)}))
    else $error("Winner status read wrong");

  c_irq_seen:   cover property (INT_OUT ##1 !INT_OUT);
  c_tie_low:    cover property (act == 37'h28 ##1 CORE_IRQ.vector == 5'h03);
  c_fetch_seen: cover property (EXC_SEL == ivpm_pkg::EXC_FETCH);
  c_nmi_over:   cover property (NMI_REQ && found ##1 EXC_SEL == ivpm_pkg::EXC_NMI);
  c_shared_uart: cover property ((act[28:26] == 3'h7) ##1 CORE_IRQ.vector == 5'h18);

endmodule
`default_nettype wire
